// ==== rtl/stop_supervisor_pkg.sv ====
// Notes on behaviour
// - group-one alarm stops as servo-off, per stop_mode_select; applied after restart.
// - group-two alarm: zero-speed stop then after-stop state; select 1 follows stop mode.
// - alarm2_stop_select honoured only in position and speed control.
// - force control uses stop_mode_select alone for group-two alarms.
// - hold time 20 to 1000 ms, default 20, takes effect at once.
// - interruption not beyond hold time keeps motor energised.
// - interruption beyond hold time removes motor power.
// - motor is energised again once main supply returns.
// - servo_ready drops when interruption exceeds hold time.
// - control supply loss acts as normal power-off, hold time ignored.
// - undervoltage alarm during interruption overrides ride-through.
// - max speed 1 to 100 x 100 mm/s, default 50, lowers overspeed threshold.
// - main DC undervoltage raises warning unless exec select is 0; output current then limited.
// - undervoltage_exec_select 1 means host alone limits, 2 drive alone, 0 neither warns nor limits.
// - servo-off stops by stop_mode_select, same meanings as group-one.
package stop_supervisor_pkg;
  localparam logic [31:0] CYCLES_PER_MS = 32'd100000;
  localparam int HOLD_MIN_MS = 20;
  localparam int HOLD_MAX_MS = 1000;
  localparam logic [9:0] HOLD_RESET = 10'd20;
  localparam logic [6:0] MAXSPD_MIN = 7'd1;
  localparam logic [6:0] MAXSPD_MAX = 7'd100;
  localparam logic [6:0] MAXSPD_RESET = 7'd50;
  // register byte offsets
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_CONTROL = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_IRQ_MASK = 4'hc;
  // config fields
  localparam int CFG_STOP_LSB = 0;
  localparam int CFG_A2SEL_BIT = 2;
  localparam int CFG_UVEXEC_LSB = 4;
  localparam int CFG_HOLD_LSB = 8;
  localparam int CFG_MAXSPD_LSB = 20;
  localparam logic [31:0] CFG_RESET = 32'h0320_1400;
  // control fields
  localparam int CTL_SERVO_ON_BIT = 0;
  localparam int CTL_RESTART_BIT = 1;
  // status / irq fields
  localparam int IRQ_TIMEOUT_BIT = 0;
  localparam int IRQ_UVWARN_BIT = 1;
  localparam int IRQ_ALARM_BIT = 2;
  localparam int IRQ_STOPPED_BIT = 3;
  localparam int IRQ_WIDTH = 4;
  localparam logic [1:0] STOP_DB_HOLD = 2'h0;
  localparam logic [1:0] STOP_DB_COAST = 2'h1;
  localparam logic [1:0] STOP_COAST = 2'h2;
  localparam logic [1:0] CTRL_POSITION = 2'h0;
  localparam logic [1:0] CTRL_SPEED = 2'h1;
  localparam logic [1:0] CTRL_FORCE = 2'h2;
  localparam logic [1:0] UV_NONE = 2'h0;
  localparam logic [1:0] UV_HOST = 2'h1;
  localparam logic [1:0] UV_DRIVE = 2'h2;
  typedef enum logic [2:0] {
    ST_OFF, ST_RUN, ST_ZERO_SPEED, ST_BRAKE, ST_COAST
  } stop_state_t;
endpackage

// ==== rtl/pin_sync.sv ====
`timescale 1ns/10ps
// three-stage input filter, change accepted when stages two and three agree
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_o <= '0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_o[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// ==== rtl/stop_supervisor.sv ====
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module stop_supervisor
  import stop_supervisor_pkg::*;
#(
  parameter logic [31:0] MS_CYCLES = CYCLES_PER_MS,
  parameter int SPEED_W = 16
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // drive status pins, asynchronous
  input wire logic main_power_ok_i,
  input wire logic control_power_ok_i,
  input wire logic dc_undervoltage_i,
  input wire logic undervoltage_alarm_i,
  input wire logic alarm_group_one_i,
  input wire logic alarm_group_two_i,
  input wire logic motor_stopped_i,
  // same-clock inputs
  input wire logic servo_off_command_i,
  input wire logic [1:0] control_mode_i,
  input wire logic [SPEED_W-1:0] speed_i,
  // drive outputs
  output logic motor_power_o,
  output logic dynamic_brake_o,
  output logic zero_speed_o,
  output logic servo_ready_o,
  output logic undervoltage_warning_o,
  output logic force_limit_o,
  output logic overspeed_alarm_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [6:0] pins;
  logic main_ok, ctl_ok, dc_uv, uv_alarm, alm1, alm2, stopped;

  pin_sync #(.WIDTH(7)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({!main_power_ok_i, !control_power_ok_i, dc_undervoltage_i,
      undervoltage_alarm_i, alarm_group_one_i, alarm_group_two_i,
      motor_stopped_i}),
    .level_o(pins)
  );
  // supplies filtered inverted, so reset reads them as present
  assign {main_ok, ctl_ok} = ~pins[6:5];
  assign {dc_uv, uv_alarm, alm1, alm2, stopped} = pins[4:0];

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] cfg_q;
  logic [31:0] act_cfg_q;
  logic servo_on_q;
  logic [IRQ_WIDTH-1:0] status_q;
  logic [IRQ_WIDTH-1:0] mask_q;
  logic [IRQ_WIDTH-1:0] events;
  logic acc, wr, rd, hit;
  logic restart_req;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  assign acc = cyc_i && stb_i && !ack_o && !err_o;
  assign hit = (adr_i == REG_CONFIG) || (adr_i == REG_CONTROL) ||
    (adr_i == REG_STATUS) || (adr_i == REG_IRQ_MASK);
  assign wr = acc && we_i && hit;
  assign rd = acc && !we_i && hit;
  assign restart_req = wr && adr_i == REG_CONTROL && sel_i[0] &&
    dat_i[CTL_RESTART_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      ack_o <= acc && hit;
      err_o <= acc && !hit;
    end
  end

  // written settings; hold time clamped to its legal range
  logic [31:0] cfg_new;
  logic [9:0] hold_new;
  logic [6:0] spd_new;
  always_comb begin
    cfg_new = merge(cfg_q, dat_i, sel_i);
    hold_new = cfg_new[CFG_HOLD_LSB +: 10];
    spd_new = cfg_new[CFG_MAXSPD_LSB +: 7];
    if (hold_new < 10'(HOLD_MIN_MS)) begin
      hold_new = 10'(HOLD_MIN_MS);
    end else if (hold_new > 10'(HOLD_MAX_MS)) begin
      hold_new = 10'(HOLD_MAX_MS);
    end
    if (spd_new < MAXSPD_MIN) begin
      spd_new = MAXSPD_MIN;
    end else if (spd_new > MAXSPD_MAX) begin
      spd_new = MAXSPD_MAX;
    end
    cfg_new[CFG_HOLD_LSB +: 10] = hold_new;
    cfg_new[CFG_MAXSPD_LSB +: 7] = spd_new;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= CFG_RESET;
    end else if (wr && adr_i == REG_CONFIG) begin
      cfg_q <= cfg_new;
    end
  end

  // restart-applied copy of settings
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_cfg_q <= CFG_RESET;
    end else if (restart_req) begin
      act_cfg_q <= cfg_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      servo_on_q <= 1'b0;
    end else if (servo_off_command_i) begin
      servo_on_q <= 1'b0;
    end else if (wr && adr_i == REG_CONTROL && sel_i[0]) begin
      servo_on_q <= dat_i[CTL_SERVO_ON_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= '0;
    end else if (wr && adr_i == REG_IRQ_MASK && sel_i[0]) begin
      mask_q <= dat_i[IRQ_WIDTH-1:0];
    end
  end

  // sticky status, read clears, a new event wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= '0;
    end else if (rd && adr_i == REG_STATUS) begin
      status_q <= events;
    end else begin
      status_q <= status_q | events;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power interruption timing
  logic [31:0] ms_cnt_q;
  logic [9:0] out_ms_q;
  logic timed_out_q;
  logic [1:0] stop_sel, uv_sel;
  logic a2_sel;
  logic [9:0] hold_ms;
  logic [6:0] max_spd;

  assign stop_sel = act_cfg_q[CFG_STOP_LSB +: 2];
  assign a2_sel = act_cfg_q[CFG_A2SEL_BIT];
  assign uv_sel = act_cfg_q[CFG_UVEXEC_LSB +: 2];
  assign max_spd = act_cfg_q[CFG_MAXSPD_LSB +: 7];
  assign hold_ms = cfg_q[CFG_HOLD_LSB +: 10];

  always_ff @(posedge clk_i) begin
    if (rst_i || main_ok) begin
      ms_cnt_q <= '0;
      out_ms_q <= '0;
    end else if (ms_cnt_q == MS_CYCLES - 32'd1) begin
      ms_cnt_q <= '0;
      if (out_ms_q != 10'h3ff) begin
        out_ms_q <= out_ms_q + 10'd1;
      end
    end else begin
      ms_cnt_q <= ms_cnt_q + 32'd1;
    end
  end

  // outage beyond hold, or control loss or undervoltage alarm
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timed_out_q <= 1'b0;
    end else if (main_ok && ctl_ok && !uv_alarm) begin
      timed_out_q <= 1'b0;
    end else if (!ctl_ok) begin
      timed_out_q <= 1'b1;
    end else if (uv_alarm && !main_ok) begin
      timed_out_q <= 1'b1;
    end else if (out_ms_q > hold_ms) begin
      timed_out_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stop sequencer
  stop_state_t state_q;
  logic a2_zero;

  // group-two zero-speed only outside force control
  assign a2_zero = !a2_sel && control_mode_i != CTRL_FORCE;

  function automatic stop_state_t direct_stop(input logic [1:0] sel);
    return (sel == STOP_COAST) ? ST_COAST : ST_BRAKE;
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_OFF;
    end else begin
      unique case (state_q)
        ST_OFF: begin
          if (servo_on_q && !timed_out_q && !alm1 && !alm2) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (alm1 || !servo_on_q) begin
            state_q <= direct_stop(stop_sel);
          end else if (alm2) begin
            state_q <= a2_zero ? ST_ZERO_SPEED :
              direct_stop(stop_sel);
          end
          // interruption within hold time keeps running
        end
        ST_ZERO_SPEED: begin
          if (alm1 || !servo_on_q) begin
            state_q <= direct_stop(stop_sel);
          end else if (stopped) begin
            state_q <= (stop_sel == STOP_DB_HOLD) ? ST_BRAKE :
              ST_COAST;
          end
        end
        ST_BRAKE: begin
          if (stop_sel != STOP_DB_HOLD && stopped) begin
            state_q <= ST_COAST;
          end
        end
        ST_COAST: begin
          if (!alm1 && !alm2 && !servo_on_q) begin
            state_q <= ST_OFF;
          end
        end
        default: state_q <= ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      motor_power_o <= 1'b0;
      zero_speed_o <= 1'b0;
      dynamic_brake_o <= 1'b0;
    end else begin
      motor_power_o <= (state_q == ST_RUN || state_q == ST_ZERO_SPEED) &&
        !timed_out_q && servo_on_q && !servo_off_command_i;
      zero_speed_o <= state_q == ST_ZERO_SPEED;
      dynamic_brake_o <= state_q == ST_BRAKE ||
        (state_q == ST_RUN && timed_out_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      servo_ready_o <= 1'b0;
    end else begin
      servo_ready_o <= !timed_out_q && ctl_ok &&
        !alm1 && !alm2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // undervoltage warning and force limit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      undervoltage_warning_o <= 1'b0;
      force_limit_o <= 1'b0;
    end else begin
      undervoltage_warning_o <= dc_uv && uv_sel != UV_NONE;
      // host mode relies on host limiting
      force_limit_o <= dc_uv && uv_sel == UV_DRIVE;
    end
  end

  // overspeed threshold is max speed times 100, in speed_i units
  logic [SPEED_W+6:0] spd_limit;
  assign spd_limit = (SPEED_W+7)'(max_spd) * (SPEED_W+7)'(100);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overspeed_alarm_o <= 1'b0;
    end else begin
      overspeed_alarm_o <= (SPEED_W+7)'(speed_i) > spd_limit;
    end
  end

  assign events = {IRQ_WIDTH{1'b0}} |
    (IRQ_WIDTH'(timed_out_q && !servo_ready_o) << IRQ_TIMEOUT_BIT) |
    (IRQ_WIDTH'(dc_uv && !undervoltage_warning_o) << IRQ_UVWARN_BIT) |
    (IRQ_WIDTH'(alm1 || alm2) << IRQ_ALARM_BIT) |
    (IRQ_WIDTH'(state_q == ST_ZERO_SPEED && stopped) << IRQ_STOPPED_BIT);

  ////////////////////////////////////////////////////////////////////////////
  // read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (rd) begin
      unique case (adr_i)
        REG_CONFIG: dat_o <= cfg_q;
        REG_CONTROL: dat_o <= {30'h0, 1'b0, servo_on_q};
        REG_STATUS: dat_o <= {28'h0, status_q};
        default: dat_o <= {28'h0, mask_q};
      endcase
    end
  end
endmodule

// ==== test/stop_supervisor_checker.sv ====
`timescale 1ns/10ps
module stop_supervisor_checker
  import stop_supervisor_pkg::*;
#(
  parameter logic [31:0] MS_CYCLES = CYCLES_PER_MS,
  parameter int SPEED_W = 16
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic err_o,
  // drive side
  input wire logic main_power_ok_i,
  input wire logic control_power_ok_i,
  input wire logic dc_undervoltage_i,
  input wire logic undervoltage_alarm_i,
  input wire logic servo_off_command_i,
  input wire logic [SPEED_W-1:0] speed_i,
  input wire logic motor_power_o,
  input wire logic dynamic_brake_o,
  input wire logic zero_speed_o,
  input wire logic servo_ready_o,
  input wire logic undervoltage_warning_o,
  input wire logic overspeed_alarm_o
);
  localparam int LONG_CUT = (HOLD_MAX_MS + 2) * int'(MS_CYCLES) + 8;
  logic [31:0] cut_q;
  // cycles of main supply loss
  always_ff @(posedge clk_i) begin
    if (rst_i || main_power_ok_i) cut_q <= 32'h0;
    else if (cut_q != 32'hffffffff) cut_q <= cut_q + 32'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next_cycle: assert property (
    cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o)
    else $error("bus answer late");
  a_reset_outputs_low: assert property (
    $fell(rst_i) |-> !motor_power_o && !servo_ready_o)
    else $error("outputs high after reset");
  a_long_cut_off: assert property (
    cut_q > LONG_CUT |-> !servo_ready_o && !motor_power_o)
    else $error("long cut kept motor on");
  a_ctrl_loss_ready: assert property (
    (!main_power_ok_i && !control_power_ok_i) [*8] |=> !servo_ready_o)
    else $error("ready kept on control loss");
  a_uv_alarm_ready: assert property (
    (!main_power_ok_i && undervoltage_alarm_i) [*8] |=> !servo_ready_o)
    else $error("ready kept on uv alarm");
  a_servo_off_cut: assert property (
    servo_off_command_i |-> ##[1:6] !motor_power_o)
    else $error("servo off did not cut power");
  a_zero_speed_coast: assert property (
    zero_speed_o |-> !dynamic_brake_o)
    else $error("brake during zero speed");
  a_overspeed_high: assert property (
    (speed_i > 10000) [*3] |-> overspeed_alarm_o)
    else $error("overspeed missed");
  a_no_uv_no_warn: assert property (
    (!dc_undervoltage_i) [*8] |=> !undervoltage_warning_o)
    else $error("warning without undervoltage");
  c_bus_error: cover property (err_o);
  c_zero_speed: cover property ($fell(zero_speed_o));
  c_ready_drop: cover property ($fell(servo_ready_o));
endmodule
////////////////////////////////////////////////////////////////////////////
bind stop_supervisor stop_supervisor_checker #(
  .MS_CYCLES(MS_CYCLES), .SPEED_W(SPEED_W)
) checker_i (
  .clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .err_o, .main_power_ok_i,
  .control_power_ok_i, .dc_undervoltage_i, .undervoltage_alarm_i,
  .servo_off_command_i, .speed_i, .motor_power_o, .dynamic_brake_o,
  .zero_speed_o, .servo_ready_o, .undervoltage_warning_o, .overspeed_alarm_o
);

// ==== test/host_model.sv ====
`timescale 1ns/10ps
module host_model (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // bench requests
  input wire logic off_req_i,
  input wire logic slow_i,
  input wire logic host_mode_i,
  // drive side
  input wire logic undervoltage_warning_i,
  output logic servo_off_command_o,
  output logic host_force_limit_o
);
  logic req_q;
  always_ff @(posedge clk_i) begin
    req_q <= !rst_i && off_req_i;
  end
  // servo off at once or a cycle late
  always_ff @(posedge clk_i) begin
    servo_off_command_o <= !rst_i && (slow_i ? req_q : off_req_i);
  end
  // limit while warned, lifted once cleared
  always_ff @(posedge clk_i) begin
    host_force_limit_o <= !rst_i && host_mode_i && undervoltage_warning_i;
  end
endmodule

// ==== test/test_stop_supervisor.sv ====
`timescale 1ns/10ps
module test_stop_supervisor
  import stop_supervisor_pkg::*;
;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, irq_o, er;
  logic [3:0] adr_i, sel_i;
  logic [31:0] dat_i, dat_o, rd, seed, cfg, w;
  logic main_power_ok_i, control_power_ok_i, dc_undervoltage_i;
  logic undervoltage_alarm_i, alarm_group_one_i, alarm_group_two_i;
  logic motor_stopped_i, servo_off_command_i, off_req, slow, host_mode;
  logic [1:0] control_mode_i;
  logic [15:0] speed_i;
  logic motor_power_o, dynamic_brake_o, zero_speed_o, servo_ready_o;
  logic undervoltage_warning_o, force_limit_o, overspeed_alarm_o, host_limit;
  logic [7:0] c;
  // stop case: [1:0] stop, [2] a2 sel, [4:3] mode, [6:5] cause, [7] zero
  logic [7:0] cases [0:8] = '{8'h00, 8'h09, 8'h02, 8'h21, 8'hc0, 8'hca,
    8'h45, 8'h50, 8'h55};
  int errors, checks, i, j, k;
  stop_supervisor #(.MS_CYCLES(32'd10)) stop_supervisor_i (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .err_o, .main_power_ok_i, .control_power_ok_i,
    .dc_undervoltage_i, .undervoltage_alarm_i, .alarm_group_one_i,
    .alarm_group_two_i, .motor_stopped_i, .servo_off_command_i,
    .control_mode_i, .speed_i, .motor_power_o, .dynamic_brake_o,
    .zero_speed_o, .servo_ready_o, .undervoltage_warning_o, .force_limit_o,
    .overspeed_alarm_o, .irq_o
  );
  host_model host_model_i (
    .clk_i, .rst_i, .off_req_i(off_req), .slow_i(slow),
    .host_mode_i(host_mode), .undervoltage_warning_i(undervoltage_warning_o),
    .servo_off_command_o(servo_off_command_i), .host_force_limit_o(host_limit)
  );
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] cfg_model(input logic [31:0] v);
    int h, s;
    h = v[17:8];
    s = v[26:20];
    h = h < HOLD_MIN_MS ? HOLD_MIN_MS : h > HOLD_MAX_MS ? HOLD_MAX_MS : h;
    s = s < 1 ? 1 : s > 100 ? 100 : s;
    return (v & ~32'h07f3_ff00) | (h << 8) | (s << 20);
  endfunction
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic wr, input logic [3:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, wr, a, s, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
    rd = dat_o;
    er = err_o;
    {cyc_i, stb_i} <= 2'h0;
    if (n >= 20) begin
      errors++;
      end_of_test();
    end
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    cyc(4);
    rst_i <= 1'b0;
    cyc(1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_i, cyc_i, stb_i, we_i, off_req, slow, host_mode} = 7'h40;
    {adr_i, sel_i, dat_i, control_mode_i, speed_i} = '0;
    {main_power_ok_i, control_power_ok_i, dc_undervoltage_i} = 3'h6;
    {undervoltage_alarm_i, alarm_group_one_i, alarm_group_two_i} = 3'h0;
    motor_stopped_i = 1'b0;
    {errors, checks, seed} = {32'h0, 32'h0, 32'hd203f31e};
    do_reset();
    wb(1'b0, REG_CONFIG, 4'hf, 32'h0);
    chk(rd, CFG_RESET);
    wb(1'b0, 4'h6, 4'hf, 32'h0);
    chk(er, 1'b1);
    cfg = CFG_RESET;
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      w = seed;
      if (w[1:0] == 2'h3) w[1:0] = 2'h2;
      if (w[5:4] == 2'h3) w[5:4] = 2'h2;
      wb(1'b1, REG_CONFIG, i[0] ? 4'h1 : 4'hf, w);
      cfg = cfg_model(i[0] ? {cfg[31:8], w[7:0]} : w);
      wb(1'b0, REG_CONFIG, 4'hf, 32'h0);
      chk(rd, cfg);
    end
    $display("done config");
    do_reset();
    for (i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      k = i == 0 ? 5000 : i == 1 ? 5001 : i == 2 ? 12000 : seed % 10000;
      speed_i <= k[15:0];
      cyc(3);
      chk(overspeed_alarm_o, k > 5000);
    end
    wb(1'b1, REG_CONFIG, 4'hf, (CFG_RESET & ~32'h07f0_0000) | 32'h0010_0000);
    for (j = 0; j < 2; j++) begin
      if (j == 1) wb(1'b1, REG_CONTROL, 4'hf, 32'h2);
      for (k = 100; k < 102; k++) begin
        speed_i <= k[15:0];
        cyc(3);
        chk(overspeed_alarm_o, j == 1 && k > 100);
      end
    end
    speed_i <= 16'h0;
    $display("done speed");
    for (i = 0; i < 9; i++) begin
      c = cases[i];
      do_reset();
      wb(1'b1, REG_CONFIG, 4'hf, CFG_RESET | {29'h0, c[2:0]});
      wb(1'b1, REG_CONTROL, 4'hf, 32'h2);
      wb(1'b1, REG_CONTROL, 4'hf, 32'h1);
      control_mode_i <= c[4:3];
      slow <= i[0];
      cyc(12);
      chk(motor_power_o, 1'b1);
      off_req <= c[6:5] == 2'h0;
      alarm_group_one_i <= c[6:5] == 2'h1;
      alarm_group_two_i <= c[6:5] == 2'h2;
      cyc(12);
      chk(zero_speed_o, c[7]);
      chk(dynamic_brake_o, !c[7] && c[1:0] != 2'h2);
      motor_stopped_i <= 1'b1;
      cyc(12);
      chk(zero_speed_o, 1'b0);
      chk(dynamic_brake_o, c[1:0] == 2'h0);
      chk(motor_power_o, 1'b0);
      {off_req, alarm_group_one_i, alarm_group_two_i, motor_stopped_i} <= '0;
    end
    $display("done stop");
    for (i = 0; i < 4; i++) begin
      do_reset();
      wb(1'b1, REG_IRQ_MASK, 4'hf, 32'h1);
      wb(1'b1, REG_CONTROL, 4'hf, 32'h1);
      cyc(12);
      main_power_ok_i <= 1'b0;
      control_power_ok_i <= i != 2;
      undervoltage_alarm_i <= i == 3;
      cyc(i == 0 ? 150 : i == 1 ? 10040 : 20);
      chk(motor_power_o, i == 0);
      chk(servo_ready_o, i == 0);
      chk(irq_o, i != 0);
      {main_power_ok_i, control_power_ok_i, undervoltage_alarm_i} <= 3'h6;
      cyc(12);
      chk(motor_power_o, 1'b1);
      wb(1'b0, REG_STATUS, 4'hf, 32'h0);
      chk(rd[IRQ_TIMEOUT_BIT], i != 0);
      cyc(2);
      chk(irq_o, 1'b0);
    end
    $display("done power cut");
    for (i = 1; i < 3; i++) begin
      do_reset();
      wb(1'b1, REG_CONFIG, 4'hf, CFG_RESET | (i << 4));
      wb(1'b1, REG_CONTROL, 4'hf, 32'h2);
      host_mode <= i == 1;
      dc_undervoltage_i <= 1'b1;
      cyc(12);
      chk(undervoltage_warning_o, 1'b1);
      chk(host_limit, i == 1);
      chk(force_limit_o, i == 2);
      dc_undervoltage_i <= 1'b0;
      cyc(12);
      chk(undervoltage_warning_o, 1'b0);
      chk(host_limit, 1'b0);
    end
    $display("done undervoltage");
    end_of_test();
  end
endmodule
